// [logic/bid_decoder.v]
// Chosen here: register access over AHB-Lite and the register addresses.
`timescale 1ns/1ps
`include "bid_regs.vh"
// Overview of operation
// - Each conditional branch decodes in short and long form with one shared test.
// - Short branches are two bytes and three cycles, taken or not.
// - Prefix 10 plus a short conditional opcode gives the long 16-bit form.
// - Long conditional branches are four bytes; six cycles taken, five not.
// - Opcode 20 always jumps, 3 cycles 2 bytes; 16 does so, 5 cycles 3 bytes.
// - Opcode 21 never jumps, 2 bytes 3 cycles; 1021 never jumps, 4 bytes 5 cycles.
// - Relative call saves return; short 7 cycles 2 bytes, opcode 17 9 cycles 3 bytes.
// - Opcode 2B jumps when negative is set.
// - Opcode 2A jumps when negative is clear.
// - Opcode 26 jumps on zero clear, 27 on zero set.
// - Opcode 28 jumps on overflow clear, 29 on overflow set.
// - Signed tests 2E, 2F, 2C, 2D; each pair complements the other.
// - Unsigned tests 22, 23, 24, 25; 22/23 and 24/25 are complements.
// - Postbyte bits 6:5 pick X, Y, user stack or hardware stack pointer.
// - Bit 7 clear adds signed 5-bit offset; others add zero, 8 or 16 bits.
// - Accumulator offsets A, B, D cost one, one and four extra cycles.
// - Post-increment by 1 or 2, pre-decrement by 1 or 2, two or three cycles.
// - Bit 4 selects indirection; single-step auto forms are refused as indirect.
// - PC-relative forms ignore the pointer field, add 8 or 16 bit offset to PC.
// - Postbyte 9F takes a 16-bit address and fetches indirectly, five cycles more.
// - Opcode 24 jumps on carry clear, opcode 25 on carry set.
// - Opcode 22 jumps only when carry and zero are both clear.
module bid_decoder #(
  parameter ADDR_W = 12
) (
  input wire mclk_i,
  input wire rst_b_i,
  input wire hsel_i,
  input wire [31:0] haddr_i,
  input wire [1:0] htrans_i,
  input wire hwrite_i,
  input wire [2:0] hsize_i,
  input wire [31:0] hwdata_i,
  input wire hready_i,
  output reg [31:0] hrdata_o,
  output reg hreadyout_o,
  output reg hresp_o,
  output reg done_o
);

  // ----------------------------------------------------------------
  // Indexed mode codes
  // ----------------------------------------------------------------
  localparam [3:0] MODE_NONE = 4'h0;
  localparam [3:0] MODE_OFF5 = 4'h1;
  localparam [3:0] MODE_OFF0 = 4'h2;
  localparam [3:0] MODE_OFF8 = 4'h3;
  localparam [3:0] MODE_OFF16 = 4'h4;
  localparam [3:0] MODE_ACC_A = 4'h5;
  localparam [3:0] MODE_ACC_B = 4'h6;
  localparam [3:0] MODE_ACC_D = 4'h7;
  localparam [3:0] MODE_INC1 = 4'h8;
  localparam [3:0] MODE_INC2 = 4'h9;
  localparam [3:0] MODE_DEC1 = 4'ha;
  localparam [3:0] MODE_DEC2 = 4'hb;
  localparam [3:0] MODE_PC8 = 4'hc;
  localparam [3:0] MODE_PC16 = 4'hd;
  localparam [3:0] MODE_EXT_IND = 4'he;
  localparam [3:0] MODE_ILLEGAL = 4'hf;

  // One-hot bus states
  localparam [1:0] ST_IDLE = 2'b01;
  localparam [1:0] ST_DATA = 2'b10;

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  reg [1:0] state_reg;
  reg [ADDR_W-1:0] addr_reg;
  reg wr_reg;
  reg [15:0] opc_reg;
  reg [3:0] flags_reg;
  reg [15:0] pc_reg;
  reg [23:0] operand_reg;
  reg [31:0] br_stat_reg;
  reg [15:0] target_reg;
  reg [31:0] idx_stat_reg;
  reg go_reg;

  // Branch condition on N Z V C; low bit of opcode inverts the even test
  function cond_true;
    input [3:0] code;
    input [3:0] f;
    reg n;
    reg z;
    reg v;
    reg c;
    reg base;
    begin
      n = f[`BID_FLAG_N_BIT];
      z = f[`BID_FLAG_Z_BIT];
      v = f[`BID_FLAG_V_BIT];
      c = f[`BID_FLAG_C_BIT];
      case (code[3:1])
        3'h0: base = 1'b1; // 20 always, 21 never
        3'h1: base = ~c & ~z;
        3'h2: base = ~c;
        3'h3: base = ~z;
        3'h4: base = ~v;
        3'h5: base = ~n;
        3'h6: base = ~(n ^ v);
        default: base = ~((n ^ v) | z);
      endcase
      cond_true = code[0] ? ~base : base;
    end
  endfunction

  // ----------------------------------------------------------------
  // Branch decode
  // ----------------------------------------------------------------
  reg [7:0] op;
  reg is_long;
  reg valid_br;
  reg taken;
  reg is_call;
  reg [3:0] br_bytes;
  reg [4:0] br_cycles;
  reg [15:0] disp;
  reg [15:0] br_target;

  // Decoded combinationally from the loaded opcode and flags
  always @*
  begin
    op = opc_reg[7:0];
    is_long = (opc_reg[15:8] == `BID_PREFIX_LONG);
    valid_br = 1'b0;
    taken = 1'b0;
    is_call = 1'b0;
    br_bytes = 4'h0;
    br_cycles = 5'h00;
    disp = 16'h0000;
    if (!is_long && op == `BID_OP_ALWAYS_FAR)
    begin
      valid_br = 1'b1;
      taken = 1'b1;
      br_bytes = `BID_ALWAYS_FAR_BYTES;
      br_cycles = `BID_ALWAYS_FAR_CYCLES;
      disp = operand_reg[15:0];
    end
    else if (!is_long && (op == `BID_OP_CALL_FAR || op == `BID_OP_CALL_SHORT))
    begin
      valid_br = 1'b1;
      taken = 1'b1;
      is_call = 1'b1;
      if (op == `BID_OP_CALL_FAR)
      begin
        br_bytes = `BID_ALWAYS_FAR_BYTES;
        br_cycles = `BID_CALL_FAR_CYCLES;
        disp = operand_reg[15:0];
      end
      else
      begin
        br_bytes = `BID_SHORT_BYTES;
        br_cycles = `BID_CALL_SHORT_CYCLES;
        disp = {{8{operand_reg[7]}}, operand_reg[7:0]};
      end
    end
    else if (op[7:4] == 4'h2 && !(is_long && op == `BID_OP_ALWAYS_SHORT))
    begin
      valid_br = 1'b1;
      taken = cond_true(op[3:0], flags_reg);
      if (is_long)
      begin
        br_bytes = `BID_LONG_BYTES;
        br_cycles = (taken && op != `BID_OP_NEVER_SHORT) ? `BID_LONG_TAKEN_CYCLES : `BID_LONG_NOT_CYCLES;
        disp = operand_reg[15:0];
      end
      else
      begin
        br_bytes = `BID_SHORT_BYTES;
        br_cycles = `BID_SHORT_CYCLES;
        disp = {{8{operand_reg[7]}}, operand_reg[7:0]};
      end
    end
    // Target is relative to the byte after the whole instruction
    br_target = pc_reg + {12'h000, br_bytes} + (taken ? disp : 16'h0000);
  end

  // ----------------------------------------------------------------
  // Indexed postbyte decode
  // ----------------------------------------------------------------
  reg [7:0] pb;
  reg [3:0] idx_mode;
  reg indirect;
  reg [3:0] xcyc;
  reg [1:0] xbytes;
  reg [15:0] idx_offset;
  reg pcrel;

  // Postbyte sits in operand bits 7:0, following bytes above it
  always @*
  begin
    pb = operand_reg[7:0];
    indirect = pb[7] & pb[4];
    pcrel = pb[7] & ((pb[3:0] == 4'hc) | (pb[3:0] == 4'hd));
    idx_mode = MODE_ILLEGAL;
    xcyc = 4'h0;
    xbytes = 2'h0;
    idx_offset = 16'h0000;
    if (!pb[7])
    begin
      idx_mode = MODE_OFF5;
      xcyc = `BID_IDX_OFF5_CYCLES;
      idx_offset = {{11{pb[4]}}, pb[4:0]};
    end
    else
    begin
      // Low nibble picks the form; bit 4 marks indirection on top of it
      case (pb[3:0])
        4'h0:
        begin
          // A single-step increment cannot be indirect
          idx_mode = pb[4] ? MODE_ILLEGAL : MODE_INC1;
          xcyc = `BID_IDX_STEP1_CYCLES;
        end
        4'h1:
        begin
          idx_mode = MODE_INC2;
          xcyc = `BID_IDX_STEP2_CYCLES;
        end
        4'h2:
        begin
          idx_mode = pb[4] ? MODE_ILLEGAL : MODE_DEC1;
          xcyc = `BID_IDX_STEP1_CYCLES;
        end
        4'h3:
        begin
          idx_mode = MODE_DEC2;
          xcyc = `BID_IDX_STEP2_CYCLES;
        end
        4'h4: idx_mode = MODE_OFF0;
        4'h5:
        begin
          idx_mode = MODE_ACC_B;
          xcyc = `BID_IDX_ACC8_CYCLES;
        end
        4'h6:
        begin
          idx_mode = MODE_ACC_A;
          xcyc = `BID_IDX_ACC8_CYCLES;
        end
        4'h8:
        begin
          idx_mode = MODE_OFF8;
          xcyc = `BID_IDX_OFF8_CYCLES;
          xbytes = 2'h1;
          idx_offset = {{8{operand_reg[15]}}, operand_reg[15:8]};
        end
        4'h9:
        begin
          idx_mode = MODE_OFF16;
          xcyc = `BID_IDX_OFF16_CYCLES;
          xbytes = 2'h2;
          idx_offset = operand_reg[23:8];
        end
        4'hb:
        begin
          idx_mode = MODE_ACC_D;
          xcyc = `BID_IDX_ACC16_CYCLES;
        end
        4'hc:
        begin
          // Pointer field is ignored; the offset goes onto the program counter
          idx_mode = MODE_PC8;
          xcyc = `BID_IDX_PC8_CYCLES;
          xbytes = 2'h1;
          idx_offset = {{8{operand_reg[15]}}, operand_reg[15:8]};
        end
        4'hd:
        begin
          idx_mode = MODE_PC16;
          xcyc = `BID_IDX_PC16_CYCLES;
          xbytes = 2'h2;
          idx_offset = operand_reg[23:8];
        end
        4'hf:
        begin
          // Only the zero pointer field with bit 4 set is the absolute form
          if (pb == `BID_OP_EXT_INDIRECT)
          begin
            idx_mode = MODE_EXT_IND;
            xcyc = `BID_IDX_EXT_BASE_CYCLES;
            xbytes = 2'h2;
            idx_offset = operand_reg[23:8];
          end
        end
        default: idx_mode = MODE_ILLEGAL;
      endcase
      // Indirection adds its memory fetch; the extended form lands on five in total
      if (indirect && idx_mode != MODE_ILLEGAL)
        xcyc = xcyc + `BID_IDX_INDIRECT_CYCLES;
    end
  end

  // ----------------------------------------------------------------
  // AHB-Lite slave: zero wait states, always OKAY
  // ----------------------------------------------------------------
  wire take = hsel_i & hready_i & htrans_i[1];

  // Read mux on the address-phase address
  function [31:0] rd_mux;
    input [ADDR_W-1:0] a;
    begin
      if (a == `BID_CTRL_ADDR) rd_mux = {31'h0, go_reg};
      else if (a == `BID_OPC_ADDR) rd_mux = {16'h0, opc_reg};
      else if (a == `BID_FLAGS_ADDR) rd_mux = {28'h0, flags_reg};
      else if (a == `BID_PC_ADDR) rd_mux = {16'h0, pc_reg};
      else if (a == `BID_OPERAND_ADDR) rd_mux = {8'h0, operand_reg};
      else if (a == `BID_BR_STAT_ADDR) rd_mux = br_stat_reg;
      else if (a == `BID_TARGET_ADDR) rd_mux = {16'h0, target_reg};
      else if (a == `BID_IDX_STAT_ADDR) rd_mux = idx_stat_reg;
      else rd_mux = 32'h0;
    end
  endfunction

  // Bus phases, register writes and decode capture
  always @(posedge mclk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      state_reg <= ST_IDLE;
      addr_reg <= {ADDR_W{1'b0}};
      wr_reg <= 1'b0;
      opc_reg <= 16'h0000;
      flags_reg <= 4'h0;
      pc_reg <= 16'h0000;
      operand_reg <= 24'h000000;
      br_stat_reg <= 32'h0;
      target_reg <= 16'h0000;
      idx_stat_reg <= 32'h0;
      go_reg <= 1'b0;
      hrdata_o <= 32'h0;
      hreadyout_o <= 1'b1;
      hresp_o <= 1'b0;
      done_o <= 1'b0;
    end
    else
    begin
      go_reg <= 1'b0;
      done_o <= go_reg;
      // Latch results one cycle after a go write, so inputs are settled
      if (go_reg)
      begin
        br_stat_reg <= {11'h0, is_long, is_call, taken, valid_br, br_cycles, 4'h0, br_bytes, 4'h0};
        target_reg <= br_target;
        // Mode, pointer field, offset, then pc-relative, indirect, bytes and cycles
        idx_stat_reg <= {idx_mode, pb[6:5], 2'b00, idx_offset, pcrel, indirect, xbytes, xcyc};
      end
      // A new address phase may overlap the last data phase, so writes use the held address
      if (take)
      begin
        state_reg <= ST_DATA;
        addr_reg <= haddr_i[ADDR_W-1:0];
        wr_reg <= hwrite_i;
      end
      else if (state_reg == ST_DATA)
        state_reg <= ST_IDLE;
      // Read data leaves at the address edge, so no wait state is needed
      // Limitation: a read right behind a write to the same register sees the old value
      if (take && !hwrite_i)
        hrdata_o <= rd_mux(haddr_i[ADDR_W-1:0]);
      if (state_reg == ST_DATA && wr_reg)
      begin
        if (addr_reg == `BID_CTRL_ADDR) go_reg <= hwdata_i[`BID_CTRL_GO_BIT];
        else if (addr_reg == `BID_OPC_ADDR) opc_reg <= hwdata_i[15:0];
        else if (addr_reg == `BID_FLAGS_ADDR) flags_reg <= hwdata_i[3:0];
        else if (addr_reg == `BID_PC_ADDR) pc_reg <= hwdata_i[15:0];
        else if (addr_reg == `BID_OPERAND_ADDR) operand_reg <= hwdata_i[23:0];
      end
    end
  end

endmodule // bid_decoder

// [logic/bid_regs.vh]
`ifndef BID_REGS_VH
`define BID_REGS_VH
// ----------------------------------------------------------------
// Register map (word aligned byte addresses)
// ----------------------------------------------------------------
`define BID_CTRL_ADDR 12'h000
`define BID_OPC_ADDR 12'h004
`define BID_FLAGS_ADDR 12'h008
`define BID_PC_ADDR 12'h00c
`define BID_OPERAND_ADDR 12'h010
`define BID_BR_STAT_ADDR 12'h014
`define BID_TARGET_ADDR 12'h018
`define BID_IDX_STAT_ADDR 12'h01c
// ----------------------------------------------------------------
// Field positions and codes
// ----------------------------------------------------------------
`define BID_CTRL_GO_BIT 0
`define BID_FLAG_C_BIT 0
`define BID_FLAG_V_BIT 1
`define BID_FLAG_Z_BIT 2
`define BID_FLAG_N_BIT 3
`define BID_PREFIX_LONG 8'h10
`define BID_OP_ALWAYS_SHORT 8'h20
`define BID_OP_NEVER_SHORT 8'h21
`define BID_OP_ALWAYS_FAR 8'h16
`define BID_OP_CALL_FAR 8'h17
`define BID_OP_CALL_SHORT 8'h8d
`define BID_OP_EXT_INDIRECT 8'h9f
// ----------------------------------------------------------------
// Lengths and cycle counts
// ----------------------------------------------------------------
`define BID_SHORT_BYTES 4'h2
`define BID_SHORT_CYCLES 5'h03
`define BID_LONG_BYTES 4'h4
`define BID_LONG_TAKEN_CYCLES 5'h06
`define BID_LONG_NOT_CYCLES 5'h05
`define BID_ALWAYS_FAR_BYTES 4'h3
`define BID_ALWAYS_FAR_CYCLES 5'h05
`define BID_CALL_SHORT_CYCLES 5'h07
`define BID_CALL_FAR_CYCLES 5'h09
`define BID_EXT_IND_CYCLES 5'h05
// ----------------------------------------------------------------
// Extra cycles added by indexed postbytes
// ----------------------------------------------------------------
`define BID_IDX_OFF5_CYCLES 4'h1
`define BID_IDX_OFF8_CYCLES 4'h1
`define BID_IDX_OFF16_CYCLES 4'h4
`define BID_IDX_ACC8_CYCLES 4'h1
`define BID_IDX_ACC16_CYCLES 4'h4
`define BID_IDX_STEP1_CYCLES 4'h2
`define BID_IDX_STEP2_CYCLES 4'h3
`define BID_IDX_PC8_CYCLES 4'h1
`define BID_IDX_PC16_CYCLES 4'h5
`define BID_IDX_EXT_BASE_CYCLES 4'h2
`define BID_IDX_INDIRECT_CYCLES 4'h3
`endif

// [tb/bid_decoder_asserts.sv]
`timescale 1ns/1ps
// ----
// Port checks
// ----
module bid_decoder_asserts (
  input wire mclk_i,
  input wire rst_b_i,
  input wire hsel_i,
  input wire [31:0] haddr_i,
  input wire [1:0] htrans_i,
  input wire hwrite_i,
  input wire [2:0] hsize_i,
  input wire [31:0] hwdata_i,
  input wire hready_i,
  input wire [31:0] hrdata_o,
  input wire hreadyout_o,
  input wire hresp_o,
  input wire done_o
);
  default clocking @(posedge mclk_i); endclocking
  default disable iff (!rst_b_i);
  // Taken address phases
  wire take = hsel_i & hready_i & htrans_i[1];
  wire rd = take & ~hwrite_i;
  wire [11:0] a = haddr_i[11:0];
  reg ctl_q;
  wire go = ctl_q & hwdata_i[0];
  // Control write waits here for its data phase
  always @(posedge mclk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
      ctl_q <= 1'b0;
    else
      ctl_q <= take & hwrite_i & (a == 12'h000);
  end
  ready_ok_a: assert property (hreadyout_o) else $error("wait state");
  resp_okay_a: assert property (!hresp_o) else $error("error response");
  rdata_hold_a: assert property (!$past(rd) |-> $stable(hrdata_o)) else $error("read data moved");
  done_pulse_a: assert property (done_o |=> !done_o) else $error("long done");
  go_done_a: assert property (go |-> ##[1:3] done_o) else $error("no done after go");
  done_cause_a: assert property ($rose(done_o) |-> $past(go) || $past(go, 2) || $past(go, 3))
    else $error("done without go");
  unmapped_zero_a: assert property (rd && a >= 12'h020 |=> hrdata_o == 32'h0) else $error("unmapped data");
  short_len_a: assert property (rd && a == 12'h014 |=> !(hrdata_o[17] && !hrdata_o[19] &&
    hrdata_o[7:4] == 4'h2) || hrdata_o[16:12] == 5'h03) else $error("short length");
  long_len_a: assert property (rd && a == 12'h014 |=> !(hrdata_o[17] && hrdata_o[7:4] == 4'h4) ||
    hrdata_o[16:12] == (hrdata_o[18] ? 5'h06 : 5'h05)) else $error("long length");
  ext_ind_a: assert property (rd && a == 12'h01c |=> hrdata_o[31:28] != 4'he ||
    (hrdata_o[3:0] == 4'h5 && hrdata_o[5:4] == 2'h2)) else $error("extended indirect");
endmodule // bid_decoder_asserts

// [tb/bid_ahb_master.sv]
`timescale 1ns/1ps
// ----
// Bus master in place of software
// ----
module bid_ahb_master (
  input wire logic mclk_i,
  input wire logic hready_i,
  output logic hsel_o,
  output logic [31:0] haddr_o,
  output logic [1:0] htrans_o,
  output logic hwrite_o,
  output logic [2:0] hsize_o,
  output logic [31:0] hwdata_o
);
  // Idle bus from time zero
  initial
  begin
    hsel_o = 1'b0;
    haddr_o = 32'h0;
    htrans_o = 2'b00;
    hwrite_o = 1'b0;
    hsize_o = 3'b010;
    hwdata_o = 32'h0;
  end
  // One word; waits on hready, never on a fixed count
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge mclk_i);
    hsel_o <= 1'b1;
    haddr_o <= {20'h0, a};
    htrans_o <= 2'b10;
    hwrite_o <= w;
    do @(posedge mclk_i); while (hready_i !== 1'b1);
    htrans_o <= 2'b00;
    hwdata_o <= w ? d : ~hwdata_o;
    do @(posedge mclk_i); while (hready_i !== 1'b1);
  endtask
endmodule // bid_ahb_master

// [tb/tb.sv]
`timescale 1ns/1ps
`include "bid_regs.vh"
// ----
// Bench
// ----
module tb;
  logic mclk_i = 1'b0;
  logic rst_b_i = 1'b0;
  logic hsel, hwrite, hready, hresp, done;
  logic rd_pend = 1'b0;
  logic [31:0] haddr, hwdata, hrdata;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [63:0] q[$];
  int err_total = 0;
  int n_compared = 0;
  always #2.5 mclk_i = ~mclk_i;
  bid_ahb_master bm (.mclk_i(mclk_i), .hready_i(hready), .hsel_o(hsel), .haddr_o(haddr), .htrans_o(htrans),
    .hwrite_o(hwrite), .hsize_o(hsize), .hwdata_o(hwdata));
  bid_decoder DUT (.mclk_i(mclk_i), .rst_b_i(rst_b_i), .hsel_i(hsel), .haddr_i(haddr), .htrans_i(htrans),
    .hwrite_i(hwrite), .hsize_i(hsize), .hwdata_i(hwdata), .hready_i(hready), .hrdata_o(hrdata),
    .hreadyout_o(hready), .hresp_o(hresp), .done_o(done));
  task test_done;
    if (err_total == 0 && n_compared > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  task chk(input logic [31:0] g, input logic [63:0] e);
    n_compared++;
    if (((g ^ e[31:0]) & e[63:32]) !== 32'h0)
    begin
      err_total++;
      $display("unexpected at %0t: got %h expected %h", $time, g, e[31:0]);
    end
  endtask
  // Read data phase ends: oldest note against the bus
  always @(posedge mclk_i)
  begin
    if (rd_pend && hready === 1'b1)
      chk(hrdata, q.pop_front());
    if (hready === 1'b1)
      rd_pend <= hsel & htrans[1] & ~hwrite;
  end
  task rd(input logic [11:0] a, input logic [31:0] e, input logic [31:0] mk);
    q.push_back({mk, e});
    bm.xfer(1'b0, a, $urandom);
  endtask
  task wr(input logic [11:0] a, input logic [31:0] d);
    bm.xfer(1'b1, a, d);
  endtask
  task go;
    int i;
    wr(`BID_CTRL_ADDR, 32'h1);
    for (i = 0; i < 20 && done !== 1'b1; i++) @(posedge mclk_i);
    chk({31'h0, done}, {32'h1, 32'h1});
  endtask
  // Flags are N Z V C; table indexed by the low opcode nibble
  function automatic logic cond(input logic [3:0] o, input logic [3:0] f);
    logic x;
    logic [15:0] t;
    x = f[3] ^ f[1];
    t = {f[2] | x, !f[2] & !x, x, !x, f[3], !f[3], f[1], !f[1], f[2], !f[2], f[0], !f[0], f[0] | f[2],
      !(f[0] | f[2]), 1'b0, 1'b1};
    return t[o];
  endfunction
  task br(input logic [15:0] op);
    logic [3:0] f, by;
    logic [15:0] pc, d, tg;
    logic [4:0] cy;
    logic tk, cl, lg, wide;
    f = $urandom;
    pc = $urandom;
    d = $urandom;
    lg = op[15:8] == 8'h10;
    wide = lg || op == 16'h16 || op == 16'h17;
    cl = op == 16'h17 || op == 16'h8d;
    tk = op[7:4] == 4'h2 ? cond(op[3:0], f) : 1'b1;
    by = lg ? 4'h4 : (wide ? 4'h3 : 4'h2);
    cy = op == 16'h16 ? 5'h05 : op == 16'h17 ? 5'h09 : cl ? 5'h07 : lg ? (tk ? 5'h06 : 5'h05) : 5'h03;
    tg = pc + {12'h0, by} + (tk ? (wide ? d : {{8{d[7]}}, d[7:0]}) : 16'h0);
    wr(`BID_FLAGS_ADDR, {28'h0, f});
    wr(`BID_PC_ADDR, {16'h0, pc});
    wr(`BID_OPERAND_ADDR, {16'h0, d});
    wr(`BID_OPC_ADDR, {16'h0, op});
    go;
    rd(`BID_CTRL_ADDR, 32'h0, 32'h1);
    rd(`BID_BR_STAT_ADDR, {11'h0, lg, cl, tk, 1'b1, cy, 4'h0, by, 4'h0}, 32'h001ff0f0);
    rd(`BID_TARGET_ADDR, {16'h0, tg}, 32'h0000ffff);
  endtask
  task idx(input logic [7:0] p);
    logic [3:0] md, c;
    logic [1:0] b;
    logic [15:0] r;
    logic [31:0] mk;
    logic [15:0] off;
    r = $urandom;
    {md, c} = 8'h11;
    if (p[7])
      case (p[3:0])
        4'h0: {md, c} = 8'h82;
        4'h1: {md, c} = 8'h93;
        4'h2: {md, c} = 8'ha2;
        4'h3: {md, c} = 8'hb3;
        4'h4: {md, c} = 8'h20;
        4'h5: {md, c} = 8'h61;
        4'h6: {md, c} = 8'h51;
        4'h8: {md, c} = 8'h31;
        4'h9: {md, c} = 8'h44;
        4'hb: {md, c} = 8'h74;
        4'hc: {md, c} = 8'hc1;
        4'hd: {md, c} = 8'hd5;
        4'hf: {md, c} = p == 8'h9f ? 8'he2 : 8'hf0;
        default: {md, c} = 8'hf0;
      endcase
    if (p[7] && p[4] && (md == 4'h8 || md == 4'ha))
      md = 4'hf;
    else if (p[7] && p[4] && md != 4'hf)
      c = c + 4'h3;
    b = (md == 4'h3 || md == 4'hc) ? 2'h1 : (md == 4'h4 || md == 4'hd || md == 4'he) ? 2'h2 : 2'h0;
    // Offset field: sign-extended short forms, raw following bytes for the wide ones
    off = md == 4'h1 ? {{11{p[4]}}, p[4:0]} : (md == 4'h3 || md == 4'hc) ? {{8{r[7]}}, r[7:0]} :
      (md == 4'h4 || md == 4'hd || md == 4'he) ? r : 16'h0;
    mk = md == 4'hf ? 32'hf0000000 : md < 4'hc ? 32'hfcffffff : 32'hf0ffffff;
    wr(`BID_OPERAND_ADDR, {8'h0, r, p});
    go;
    rd(`BID_IDX_STAT_ADDR, {md, p[6:5], 2'h0, off, md == 4'hc || md == 4'hd, p[7] & p[4] & (md != 4'hf),
      b, c}, mk);
  endtask
  // Main sequence
  initial
  begin
    int k, o;
    void'($urandom(32'h4b8a));
    repeat (16) @(posedge mclk_i);
    rst_b_i <= 1'b1;
    wr(12'h020, 32'hffffffff);
    rd(12'h020, 32'h0, 32'hffffffff);
    for (k = 0; k < 4; k++)
      for (o = 0; o < 16; o++)
      begin
        br({12'h002, o[3:0]});
        if (o != 0)
          br({12'h102, o[3:0]});
      end
    br(16'h0016);
    br(16'h0017);
    br(16'h008d);
    for (k = 0; k < 256; k++)
      idx(k[7:0]);
    // Let the last data phase be compared before the verdict
    repeat (2) @(posedge mclk_i);
    if (q.size() != 0)
    begin
      err_total++;
      $display("unexpected at %0t: got %h expected %h", $time, q.size(), 0);
    end
    test_done;
  end
  // Hang guard, well beyond the expected run
  initial
  begin
    repeat (40000) @(posedge mclk_i);
    err_total++;
    test_done;
  end
endmodule // tb
bind bid_decoder bid_decoder_asserts chk (.mclk_i(mclk_i), .rst_b_i(rst_b_i), .hsel_i(hsel_i),
  .haddr_i(haddr_i), .htrans_i(htrans_i), .hwrite_i(hwrite_i), .hsize_i(hsize_i), .hwdata_i(hwdata_i),
  .hready_i(hready_i), .hrdata_o(hrdata_o), .hreadyout_o(hreadyout_o), .hresp_o(hresp_o), .done_o(done_o));
